// [pkg/dis_pkg.sv]
// constants shared by the dual interrupt source select block
package dis_pkg;
	// ==========================================================
	// register offsets from the card's i/o base
	localparam logic [7:0] OFS_SOURCE_SELECT = 8'h20;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h24;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h30;

	// ==========================================================
	// field layout of the source select register
	localparam int SEL_FIRST_LSB = 0;
	localparam int SEL_SECOND_LSB = 2;
	localparam int SEL_FIELD_W = 2;
	localparam int SEL_USED_W = 4;
	localparam logic [3:0] SEL_RESET = 4'h0;

	// ==========================================================
	// clear and status bit positions
	localparam int BIT_FIRST = 0;
	localparam int BIT_SECOND = 1;

	// ==========================================================
	// source mode codes per line
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_FALL = 2'h1;
	localparam logic [1:0] MODE_GATE = 2'h2;
	localparam logic [1:0] MODE_COUNT = 2'h3;

	// ==========================================================
	// synchronised input vector layout
	localparam int IN_COUNT = 0;
	localparam int IN_C0 = 1;
	localparam int IN_C3 = 2;
	localparam int IN_W = 3;
endpackage

// [src/dis_irq_select.sv]
// dual interrupt request lines with selectable sources merged onto one shared pin
// How it works
// - two separate pending flags, both may pend
// - both lines share one active-low pin
// - first line: port1 c0, c3 or counter
// - second line: port2 c0, c3 or timer
// - only select bits 3:0 choose sources
// - first pair: off, c0 fall, gate mode
// - first pair 11: counter reaching zero requests
// - bits 3:2: off, c0 fall, gate mode
// - second pair 11: timer reaching zero requests
// - gate mode: c0 high blocks requests
// - gate mode: c3 low blocks requests
// - gate mode: c3 falling with c0 low requests
// - gate mode: c0 rising with c3 high requests
// - software reads which line is pending
// - source select sits at offset 0x20
// - all registers byte wide, byte accesses only
module dis_irq_select (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [7:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	output logic [7:0] io_rdata_out,
	input wire logic port1_c_bit0_in,
	input wire logic port1_c_bit3_in,
	input wire logic port2_c_bit0_in,
	input wire logic port2_c_bit3_in,
	input wire logic event_count_zero_in,
	input wire logic timer_count_zero_in,
	input wire logic pci_inta_n_in,
	output logic pci_inta_n_out,
	output logic pci_inta_oe_n_out
);
	// ==========================================================
	// helpers

	// source level for one line; a request is a rising edge of this level
	function automatic logic src_level(input logic [1:0] mode, input logic [dis_pkg::IN_W-1:0] s);
		logic lvl;
		lvl = 1'b0;
		unique case (mode)
			dis_pkg::MODE_OFF: lvl = 1'b0;
			dis_pkg::MODE_FALL: lvl = ~s[dis_pkg::IN_C0];
			// c0 high or c3 low holds the level up, so no new edge can appear
			dis_pkg::MODE_GATE: lvl = s[dis_pkg::IN_C0] | ~s[dis_pkg::IN_C3];
			dis_pkg::MODE_COUNT: lvl = s[dis_pkg::IN_COUNT];
		endcase
		return lvl;
	endfunction

	// ==========================================================
	// input synchronisers

	logic [dis_pkg::IN_W-1:0] meta1_r, sync1_r, meta2_r, sync2_r;
	logic [dis_pkg::IN_W-1:0] meta1_nxt, sync1_nxt, meta2_nxt, sync2_nxt;

	// port pins and counter outputs come from outside this clock, two flops each
	always_comb begin
		meta1_nxt = {port1_c_bit3_in, port1_c_bit0_in, event_count_zero_in};
		meta2_nxt = {port2_c_bit3_in, port2_c_bit0_in, timer_count_zero_in};
		sync1_nxt = meta1_r;
		sync2_nxt = meta2_r;
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			meta1_r <= '0;
			sync1_r <= '0;
			meta2_r <= '0;
			sync2_r <= '0;
		end else begin
			meta1_r <= meta1_nxt;
			sync1_r <= sync1_nxt;
			meta2_r <= meta2_nxt;
			sync2_r <= sync2_nxt;
		end
	end

	// ==========================================================
	// shared pin read back

	logic pin_meta_r, pin_meta_nxt, pin_sync_r, pin_sync_nxt;

	// other cards pull the same wire, so its level is foreign to this clock: two flops
	always_comb begin
		pin_meta_nxt = pci_inta_n_in;
		pin_sync_nxt = pin_meta_r;
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			pin_meta_r <= 1'b1; // released level, so no false low after reset
			pin_sync_r <= 1'b1;
		end else begin
			pin_meta_r <= pin_meta_nxt;
			pin_sync_r <= pin_sync_nxt;
		end
	end

	// ==========================================================
	// register port and edge detection

	logic [dis_pkg::SEL_USED_W-1:0] sel_r, sel_nxt;
	logic lvl1_r, lvl1_nxt, lvl2_r, lvl2_nxt;
	logic pend1_r, pend1_nxt, pend2_r, pend2_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic inta_n_r, inta_n_nxt;
	logic [1:0] mode1, mode2;
	logic set1, set2, clr1, clr2, wr_sel, wr_clr, rd_stat;

	// byte decode; only full-byte accesses exist on this port
	assign wr_sel = io_wr_in && (io_addr_in == dis_pkg::OFS_SOURCE_SELECT);
	assign wr_clr = io_wr_in && (io_addr_in == dis_pkg::OFS_IRQ_CLEAR);
	assign rd_stat = io_rd_in && (io_addr_in == dis_pkg::OFS_IRQ_STATUS);
	assign mode1 = sel_r[dis_pkg::SEL_FIRST_LSB +: dis_pkg::SEL_FIELD_W];
	assign mode2 = sel_r[dis_pkg::SEL_SECOND_LSB +: dis_pkg::SEL_FIELD_W];
	assign clr1 = wr_clr && io_wdata_in[dis_pkg::BIT_FIRST];
	assign clr2 = wr_clr && io_wdata_in[dis_pkg::BIT_SECOND];

	// next state: select latch, source levels, sticky flags, read data and pin
	always_comb begin
		sel_nxt = sel_r;
		if (wr_sel) begin
			sel_nxt = io_wdata_in[dis_pkg::SEL_USED_W-1:0]; // upper bits ignored
		end
		lvl1_nxt = src_level(mode1, sync1_r);
		lvl2_nxt = src_level(mode2, sync2_r);
		// rising source edge: c0 fall, gate edge, or count reaching zero
		set1 = lvl1_nxt && !lvl1_r;
		set2 = lvl2_nxt && !lvl2_r;
		// an event in the clearing cycle wins so it is never lost
		pend1_nxt = set1 | (pend1_r & ~clr1);
		pend2_nxt = set2 | (pend2_r & ~clr2);
		rdata_nxt = rdata_r;
		if (rd_stat) begin
			rdata_nxt = '0;
			rdata_nxt[dis_pkg::BIT_FIRST] = pend1_r;
			rdata_nxt[dis_pkg::BIT_SECOND] = pend2_r;
		end else if (io_rd_in) begin
			rdata_nxt = '0; // write-only and unmapped offsets read zero
		end
		inta_n_nxt = !(pend1_nxt | pend2_nxt);
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			sel_r <= dis_pkg::SEL_RESET;
			lvl1_r <= 1'b0;
			lvl2_r <= 1'b0;
			pend1_r <= 1'b0;
			pend2_r <= 1'b0;
			rdata_r <= '0;
			inta_n_r <= 1'b1;
		end else begin
			sel_r <= sel_nxt;
			lvl1_r <= lvl1_nxt;
			lvl2_r <= lvl2_nxt;
			pend1_r <= pend1_nxt;
			pend2_r <= pend2_nxt;
			rdata_r <= rdata_nxt;
			inta_n_r <= inta_n_nxt;
		end
	end

	// open drain: data is low whenever the enable is, so the pin is only ever pulled low
	assign io_rdata_out = rdata_r;
	assign pci_inta_n_out = inta_n_r;
	assign pci_inta_oe_n_out = inta_n_r;

	// ==========================================================
	// assertions

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);

	// register port: writes land at their own offset, everything but status reads zero
	a_sel_write_lands: assert property (
		wr_sel |=> sel_r == $past(io_wdata_in[dis_pkg::SEL_USED_W-1:0]))
		else $error("source select did not take written low nibble");

	a_select_holds: assert property (
		!wr_sel |=> sel_r == $past(sel_r))
		else $error("source select changed without a write to it");

	a_status_read: assert property (
		rd_stat |=> io_rdata_out == {6'h00, $past(pend2_r), $past(pend1_r)})
		else $error("status read shows wrong pending lines");

	a_other_reads_zero: assert property (
		(io_rd_in && !rd_stat) |=> io_rdata_out == 8'h00)
		else $error("read of another offset returned nonzero data");

	// first line: each selected source requests on its own event and nothing else
	a_fall_sets_first: assert property (
		(mode1 == dis_pkg::MODE_FALL && $past(mode1) == dis_pkg::MODE_FALL
		&& !sync1_r[dis_pkg::IN_C0] && $past(sync1_r[dis_pkg::IN_C0])) |=> pend1_r)
		else $error("first line missed c0 falling edge");

	a_fall_no_rise: assert property (
		(mode1 == dis_pkg::MODE_FALL && $past(mode1) == dis_pkg::MODE_FALL
		&& sync1_r[dis_pkg::IN_C0] && !$past(sync1_r[dis_pkg::IN_C0]) && !pend1_r) |=> !pend1_r)
		else $error("first line requested on c0 rising edge");

	a_count_sets_first: assert property (
		(mode1 == dis_pkg::MODE_COUNT && $past(mode1) == dis_pkg::MODE_COUNT
		&& $rose(sync1_r[dis_pkg::IN_COUNT])) |=> pend1_r)
		else $error("first line missed event counter zero");

	a_count_no_fall: assert property (
		(mode1 == dis_pkg::MODE_COUNT && $past(mode1) == dis_pkg::MODE_COUNT
		&& $fell(sync1_r[dis_pkg::IN_COUNT]) && !pend1_r) |=> !pend1_r)
		else $error("first line requested when counter left zero");

	a_off_stays_quiet: assert property (
		(mode1 == dis_pkg::MODE_OFF && !pend1_r) |=> !pend1_r)
		else $error("disabled first line raised a request");

	a_c0_blocks_first: assert property (
		(mode1 == dis_pkg::MODE_GATE && $past(mode1) == dis_pkg::MODE_GATE
		&& sync1_r[dis_pkg::IN_C0] && $past(sync1_r[dis_pkg::IN_C0])) |-> !set1)
		else $error("first line gate request while c0 high");

	a_gate_c3_blocks: assert property (
		(mode1 == dis_pkg::MODE_GATE && $past(mode1) == dis_pkg::MODE_GATE
		&& !sync1_r[dis_pkg::IN_C3] && !$past(sync1_r[dis_pkg::IN_C3])) |-> !set1)
		else $error("gate mode request while c3 low");

	a_gate_c3_fall: assert property (
		(mode1 == dis_pkg::MODE_GATE && $past(mode1) == dis_pkg::MODE_GATE
		&& !sync1_r[dis_pkg::IN_C0] && !$past(sync1_r[dis_pkg::IN_C0])
		&& !sync1_r[dis_pkg::IN_C3] && $past(sync1_r[dis_pkg::IN_C3])) |=> pend1_r)
		else $error("first line missed c3 fall with c0 low");

	// second line: same decode on its own bit pair and inputs
	a_fall_sets_second: assert property (
		(mode2 == dis_pkg::MODE_FALL && $past(mode2) == dis_pkg::MODE_FALL
		&& !sync2_r[dis_pkg::IN_C0] && $past(sync2_r[dis_pkg::IN_C0])) |=> pend2_r)
		else $error("second line missed c0 falling edge");

	a_count_sets_second: assert property (
		(mode2 == dis_pkg::MODE_COUNT && $past(mode2) == dis_pkg::MODE_COUNT
		&& $rose(sync2_r[dis_pkg::IN_COUNT])) |=> pend2_r)
		else $error("second line missed timer zero");

	a_second_off_quiet: assert property (
		(mode2 == dis_pkg::MODE_OFF && !pend2_r) |=> !pend2_r)
		else $error("disabled second line raised a request");

	a_gate_c0_blocks: assert property (
		(mode2 == dis_pkg::MODE_GATE && $past(mode2) == dis_pkg::MODE_GATE
		&& sync2_r[dis_pkg::IN_C0] && $past(sync2_r[dis_pkg::IN_C0])) |-> !set2)
		else $error("gate mode request while c0 high");

	a_c3_blocks_second: assert property (
		(mode2 == dis_pkg::MODE_GATE && $past(mode2) == dis_pkg::MODE_GATE
		&& !sync2_r[dis_pkg::IN_C3] && !$past(sync2_r[dis_pkg::IN_C3])) |-> !set2)
		else $error("second line gate request while c3 low");

	a_gate_c0_rise: assert property (
		(mode2 == dis_pkg::MODE_GATE && $past(mode2) == dis_pkg::MODE_GATE
		&& sync2_r[dis_pkg::IN_C3] && $past(sync2_r[dis_pkg::IN_C3])
		&& sync2_r[dis_pkg::IN_C0] && !$past(sync2_r[dis_pkg::IN_C0])) |=> pend2_r)
		else $error("second line missed c0 rise with c3 high");

	// sticky flags: held until cleared, and a new event beats the clear in one cycle
	a_flag_held: assert property (
		(pend1_r && !clr1) |=> pend1_r)
		else $error("first pending flag dropped without clear");

	a_second_flag_held: assert property (
		(pend2_r && !clr2) |=> pend2_r)
		else $error("second pending flag dropped without clear");

	a_first_clear_drops: assert property (
		(pend1_r && clr1 && !set1) |=> !pend1_r)
		else $error("first flag survived its clear");

	a_clear_drops: assert property (
		(pend2_r && clr2 && !set2) |=> !pend2_r)
		else $error("second flag survived its clear");

	a_set_beats_clear: assert property (
		(set1 && clr1) |=> pend1_r)
		else $error("first line event lost to a clear");

	a_second_beats_clear: assert property (
		(set2 && clr2) |=> pend2_r)
		else $error("second line event lost to a clear");

	a_both_pending: assert property (
		(pend1_r && pend2_r && !clr1 && !clr2) |=> (pend1_r && pend2_r))
		else $error("one of two pending lines was lost");

	// shared pin: pulled low while either line pends, released otherwise
	a_pin_follows: assert property (
		($rose(pend1_r) || $rose(pend2_r)) |-> !pci_inta_oe_n_out
		##1 (pci_inta_oe_n_out == !(pend1_r || pend2_r)))
		else $error("shared pin not driven for pending line");

	a_pin_released: assert property (
		(!pend1_r && !pend2_r) |-> pci_inta_oe_n_out)
		else $error("shared pin driven with no line pending");

	a_pin_readback: assert property (
		(!pci_inta_oe_n_out && !$past(pci_inta_oe_n_out) && !$past(pci_inta_oe_n_out, 2))
		|-> !pin_sync_r)
		else $error("shared pin did not read back low while driven");
endmodule

// [verification/dis_host_model.sv]
// host side of the shared interrupt pin: pull-up wire and level seen by the host
module dis_host_model (
	input wire logic inta_n_in,
	input wire logic inta_oe_n_in,
	output logic wire_n_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// pin resolution
	// released pin floats up through the board pull-up, never keeps the old level
	assign wire_n_out = inta_oe_n_in ? 1'b1 : inta_n_in;
endmodule

// [verification/dis_irq_select_tb.sv]
// self-checking bench for the dual interrupt source select block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("ERROR %s expected %h seen %h", nm, e, g); end end
module dis_irq_select_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// stimulus signals
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [5:0] src = 6'h0f; // timer, counter, port2_c_bit3, port2_c_bit0, port1_c_bit3, port1_c_bit0
	logic pin_data;
	logic pin_oe_n;
	logic pin_wire;
	int bad_count = 0;
	int total_checks = 0;
	always #20 clk_sys_in = ~clk_sys_in;
	dis_irq_select i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .io_addr_in(addr), .io_wdata_in(wdata),
		.io_wr_in(wr), .io_rd_in(rd), .io_rdata_out(rdata), .port1_c_bit0_in(src[0]), .port1_c_bit3_in(src[1]),
		.port2_c_bit0_in(src[2]), .port2_c_bit3_in(src[3]), .event_count_zero_in(src[4]),
		.timer_count_zero_in(src[5]), .pci_inta_n_in(pin_wire), .pci_inta_n_out(pin_data),
		.pci_inta_oe_n_out(pin_oe_n));
	dis_host_model i_host (.inta_n_in(pin_data), .inta_oe_n_in(pin_oe_n), .wire_n_out(pin_wire));
	// ==========================================================
	// bus and pin helpers
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_sys_in);
		wr = 1'b0;
	endtask
	// read one byte and the pin level; data is registered so look one cycle on
	task automatic read_chk(input logic [7:0] a, input logic [7:0] e, input logic p);
		@(negedge clk_sys_in);
		addr = a;
		rd = 1'b1;
		@(negedge clk_sys_in);
		rd = 1'b0;
		`CHK("read data", e, rdata)
		`CHK("shared pin", p, pin_wire)
	endtask
	// three edges reach the flag, five leaves margin
	task automatic drive(input logic [5:0] v);
		@(negedge clk_sys_in);
		src = v;
		repeat (5) @(negedge clk_sys_in);
	endtask
	task automatic complete_run();
		if (bad_count == 0 && total_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic fall_mode();
		bus_wr(8'h20, 8'h05);
		drive(6'h0e);
		read_chk(8'h24, 8'h01, 1'b0);
		drive(6'h0a);
		read_chk(8'h24, 8'h03, 1'b0);
		bus_wr(8'h30, 8'h01);
		read_chk(8'h24, 8'h02, 1'b0);
		bus_wr(8'h30, 8'h02);
		read_chk(8'h24, 8'h00, 1'b1);
		drive(6'h0f);
		read_chk(8'h24, 8'h00, 1'b1);
	endtask
	task automatic count_mode();
		bus_wr(8'h20, 8'h0f);
		drive(6'h1f);
		read_chk(8'h24, 8'h01, 1'b0);
		drive(6'h3f);
		read_chk(8'h24, 8'h03, 1'b0);
		bus_wr(8'h30, 8'h03);
		drive(6'h0f);
		read_chk(8'h24, 8'h00, 1'b1);
	endtask
	// a mode change may itself raise a request, so clear straight after it
	task automatic gate_mode();
		bus_wr(8'h20, 8'h0a);
		bus_wr(8'h30, 8'h03);
		drive(6'h0d);
		drive(6'h0c);
		read_chk(8'h24, 8'h00, 1'b1);
		drive(6'h0d);
		read_chk(8'h24, 8'h00, 1'b1);
		drive(6'h0e);
		drive(6'h0c);
		read_chk(8'h24, 8'h01, 1'b0);
		bus_wr(8'h30, 8'h01);
		drive(6'h08);
		drive(6'h0c);
		read_chk(8'h24, 8'h02, 1'b0);
		bus_wr(8'h30, 8'h02);
	endtask
	task automatic select_bits();
		bus_wr(8'h20, 8'hf0);
		bus_wr(8'h21, 8'h05);
		drive(6'h3a);
		read_chk(8'h24, 8'h00, 1'b1);
		drive(6'h0f);
		bus_wr(8'h20, 8'hf1);
		drive(6'h0e);
		read_chk(8'h20, 8'h00, 1'b0);
		read_chk(8'h24, 8'h01, 1'b0);
	endtask
	// reset in mid-run drops flags, read data and select; a c0 fall afterwards must stay quiet
	task automatic reset_mid();
		@(negedge clk_sys_in);
		reset_in = 1'b1;
		repeat (2) @(negedge clk_sys_in);
		reset_in = 1'b0;
		`CHK("reset read data", 8'h00, rdata)
		`CHK("reset shared pin", 1'b1, pin_wire)
		drive(6'h0f);
		drive(6'h0e);
		read_chk(8'h24, 8'h00, 1'b1);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		repeat (20) @(negedge clk_sys_in);
		reset_in = 1'b0;
		read_chk(8'h24, 8'h00, 1'b1);
		fall_mode();
		count_mode();
		gate_mode();
		select_bits();
		reset_mid();
		complete_run();
	end
endmodule
